/* File: ldp_bus_if.sv */
// host access events passed from bus port to core
// assumes one clock domain
`timescale 1ns/10ps
interface ldp_bus_if;
  import ldp_pkg::*;
  logic          wr_stb; // one cycle write event
  logic          rd_stb; // one cycle read end event
  logic          a0;     // data/command select of access
  logic [DW-1:0] wdata;  // captured write byte
  modport port (output wr_stb, rd_stb, a0, wdata);
  modport core (input wr_stb, rd_stb, a0, wdata);
endinterface

/* File: ldp_bus_port.sv */
// host strobe decoder for 68 and 80 style buses
// assumes strobes and data synchronous to clk
`timescale 1ns/10ps
module ldp_bus_port (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  style68,
  input  wire logic                  cs_n,
  input  wire logic                  dcs,
  input  wire logic                  stb,
  input  wire logic                  dir,
  input  wire logic [ldp_pkg::DW-1:0] din,
  output logic                       oe,
  ldp_bus_if.port                    bus
);
  import ldp_pkg::*;
  logic          stb_q;  // strobe last cycle
  logic          dir_q;  // direction or write last cycle
  logic          sel_q;  // chip selected last cycle
  logic [DW-1:0] hold;   // byte seen during strobe
  logic          a0h;    // select seen during strobe
  logic          end68;  // enable fell
  logic          wr_ev;
  logic          rd_ev;
  //////////////////////////////////////////////////////////////
  // history of the strobe pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
      dir_q <= 1'b1;
      sel_q <= 1'b0;
    end else begin
      stb_q <= stb;
      dir_q <= dir;
      sel_q <= !cs_n;
    end
  end
  // data and select caught while the strobe is active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
      a0h  <= 1'b0;
    end else if (style68 ? stb : (!stb || !dir)) begin
      hold <= din;
      a0h  <= dcs;
    end
  end
  //////////////////////////////////////////////////////////////
  // access ends; a style flip mid access may lose it
  assign end68 = stb_q && !stb;
  always_comb begin
    if (style68) begin
      wr_ev = sel_q && end68 && !dir_q;
      rd_ev = sel_q && end68 && dir_q;
    end else begin
      wr_ev = sel_q && !dir_q && dir;
      rd_ev = sel_q && !stb_q && stb;
    end
  end
  // events out as registered pulses; deselected ones dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      bus.a0     <= 1'b0;
      bus.wdata  <= '0;
    end else begin
      bus.wr_stb <= wr_ev;
      bus.rd_stb <= rd_ev;
      bus.a0     <= a0h;
      bus.wdata  <= hold;
    end
  end
  // drive enable follows the read strobe directly
  assign oe = !cs_n && (style68 ? (stb && dir) : !stb);
  //////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wr_80_edge: assert property (!style68 && sel_q && !dir_q && dir
    |=> bus.wr_stb && bus.wdata == $past(hold))
    else $error("80 write edge not taken");
  a_cs_block: assert property (!sel_q |=> !bus.wr_stb && !bus.rd_stb)
    else $error("strobe taken while deselected");
  a_rw_68_read: assert property (style68 && sel_q && stb_q && !stb && dir_q
    |=> bus.rd_stb && !bus.wr_stb)
    else $error("68 read not decoded");
  c_wr_68: cover property (style68 && wr_ev);
  c_rd_80: cover property (!style68 && rd_ev);
endmodule

/* File: ldp_drive.sv */
// level select codes for segment or common outputs
// assumes on bits and frame sampled in clk domain
`timescale 1ns/10ps
module ldp_drive #(
  parameter logic IS_COM = 1'b0,
  parameter int   N      = 16
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           fr,
  input  wire logic [N-1:0]   on,
  output logic      [2*N-1:0] sel
);
  import ldp_pkg::*;
  // four level choice from frame and on bit
  function automatic logic [1:0] lvl(input logic c, input logic f, input logic b);
    if (c)
      lvl = f ? (b ? COM_V5 : COM_V1) : (b ? COM_VDD : COM_V4);
    else
      lvl = f ? (b ? SEG_VDD : SEG_V2) : (b ? SEG_V5 : SEG_V3);
  endfunction
  //////////////////////////////////////////////////////////////
  // one registered code per output, no glitch to the switches
  for (genvar i = 0; i < N; i++) begin : g_out
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
        sel[2*i +: 2] <= IS_COM ? COM_V4 : SEG_V3;
      else
        sel[2*i +: 2] <= lvl(IS_COM, fr, on[i]);
    end
  end
  //////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_level_on: assert property (fr && on[0]
    |=> sel[1:0] == (IS_COM ? COM_V5 : SEG_VDD))
    else $error("on level wrong");
  a_level_off: assert property (!fr && !on[0]
    |=> sel[1:0] == (IS_COM ? COM_V4 : SEG_V3))
    else $error("off level wrong");
endmodule

/* File: ldp_host.sv */
// host processor model driving the lcd driver bus pins
// assumes the bench resolves the shared data bus and owns the style pin
`timescale 1ns/10ps
module ldp_host (
  input  wire logic                   clk,
  input  wire logic                   style68,
  input  wire logic [ldp_pkg::DW-1:0] bus,
  output logic                        cs_n,
  output logic                        dcs,
  output logic                        strb,
  output logic                        dirw,
  output logic      [ldp_pkg::DW-1:0] d
);
  import ldp_pkg::*;
  ////////////////////////////////////////////////
  // power-up levels: deselected, 68 style strobes parked
  initial begin
    cs_n = 1'b1;
    dcs  = 1'b0;
    strb = 1'b0;
    dirw = 1'b1;
    d    = 8'h00;
  end

  // park strobes for a new style; style passed in since the pin just moved
  task automatic idle(input logic s68);
    cs_n = 1'b1;
    strb = ~s68;
    dirw = 1'b1;
  endtask

  // one access; strobe held two cycles, answer taken at its last edge
  task automatic access(input logic wr, input logic a0, input logic sel,
                        input logic [DW-1:0] wd, output logic [DW-1:0] rd);
    @(posedge clk);
    #2 cs_n = ~sel;
    dcs = a0;
    if (wr) d = wd;
    if (style68) begin
      strb = 1'b1;
      dirw = ~wr;
    end else if (wr) begin
      dirw = 1'b0;
    end else begin
      strb = 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 rd = bus;
    #1 strb = ~style68;
    dirw = 1'b1;
    // select and data outlive the strobe by a cycle
    @(posedge clk);
    #2 cs_n = 1'b1;
    d = ~d;                     // released bus never shows the old byte
    repeat (2) @(posedge clk);
  endtask
endmodule

/* File: ldp_pkg.sv */
// constants for the lcd driver host port and panel drive logic
// assumes one clock; host pins are synchronous to it
// Behaviour
// - select low means command, high means data
// - reset pin high picks 68, low 80
// - reset acts on reset pin edges
// - active low chip select qualifies accesses
// - 68 mode enable strobe frames each access
// - 80 mode drives bus while read low
// - 68 mode direction high read, low write
// - 80 mode captures data at write rising
// - eight bit three state data port
// - both line clock edges latch and advance
// - master or slave strap changes pin roles
// - slave scans commons in reverse order
// - 32 line slave commons are 31..16
// - 16 line slave commons are 15..8; the code builds only the 32 line frame
// - segment level from ram bit and frame
// - common level from counter and frame
// - chip select high ignores strobes, not reset
// - decode data read/write, status, command
package ldp_pkg;
  localparam int DW     = 8;    // host data width
  localparam int NSEG   = 16;   // segment outputs
  localparam int NCOM   = 16;   // common outputs
  localparam int NLINE  = 32;   // lines per frame, master plus slave
  localparam int LINE_W = 5;    // line counter width
  localparam int BIT_W  = 3;    // line bit within a page byte
  localparam int COL_W  = 4;    // column counter width
  localparam int PAGE_W = 2;    // page register width
  localparam int NWORD  = 64;   // ram bytes, pages times columns
  localparam logic             HAS_COM  = 1'b1; // common driving part
  localparam logic [COL_W-1:0]  COL_RST  = 4'h0;
  localparam logic [COL_W-1:0]  COL_LAST = 4'hf;
  localparam logic [PAGE_W-1:0] PAGE_RST = 2'h3;
  localparam logic [LINE_W-1:0] LINE_RST = 5'h00;
  localparam logic [LINE_W-1:0] LINE_LAST = 5'h1f;
  // status byte bit positions
  localparam int ST_BUSY   = 7;
  localparam int ST_STYLE  = 6;
  localparam int ST_MASTER = 5;
  localparam int ST_FRAME  = 4;
  // command tags: bit 7 clear sets column, 2'h2 sets page
  localparam logic [1:0] CMD_PAGE = 2'h2;
  // segment select codes
  localparam logic [1:0] SEG_VDD = 2'h0;
  localparam logic [1:0] SEG_V2  = 2'h1;
  localparam logic [1:0] SEG_V3  = 2'h2;
  localparam logic [1:0] SEG_V5  = 2'h3;
  // common select codes
  localparam logic [1:0] COM_VDD = 2'h0;
  localparam logic [1:0] COM_V1  = 2'h1;
  localparam logic [1:0] COM_V4  = 2'h2;
  localparam logic [1:0] COM_V5  = 2'h3;
endpackage

/* File: ldp_top.sv */
// lcd driver: host port, display ram, line scan, drive codes
// assumes all pins synchronous to CLK_IN; analogue switches outside
`timescale 1ns/10ps
module ldp_top (
  input  wire logic                     CLK_IN,
  input  wire logic                     RESETN_IN,
  input  wire logic                     RESET_BUS_STYLE_IN,
  input  wire logic                     CHIP_SELECT_N_IN,
  input  wire logic                     DATA_COMMAND_SELECT_IN,
  input  wire logic                     ENABLE_READ_IN,
  input  wire logic                     DIR_WRITE_IN,
  input  wire logic [ldp_pkg::DW-1:0]   DATA_IN,
  output logic      [ldp_pkg::DW-1:0]   DATA_OUT,
  output logic                          DATA_OE_OUT,
  input  wire logic                     LINE_CLOCK_IN,
  input  wire logic                     MASTER_SEL_IN,
  input  wire logic                     FRAME_POLARITY_IN,
  output logic                          FRAME_POLARITY_OUT,
  output logic                          FRAME_POLARITY_OE_OUT,
  output logic [2*ldp_pkg::NSEG-1:0]    SEGMENT_OUTPUT_SEL_OUT,
  output logic [2*ldp_pkg::NCOM-1:0]    COMMON_OUTPUT_SEL_OUT
);
  import ldp_pkg::*;
  //////////////////////////////////////////////////////////////
  // declarations
  ldp_bus_if bus ();                  // host events
  logic                rst_q;         // reset pin last cycle
  logic                srst;          // edge of reset pin
  logic                style68;       // bus style in force
  logic                master;        // strap level
  logic [COL_W-1:0]    col;           // column counter
  logic [PAGE_W-1:0]   page;          // page register
  logic [DW-1:0]       mem [NWORD];   // display ram
  logic [DW-1:0]       rd_latch;      // read pipeline latch
  logic [DW-1:0]       status;        // status byte
  logic                lclk_q;        // line clock last cycle
  logic                lclk_edge;     // either line clock edge
  logic                frin_q;        // frame input last cycle
  logic                fr_edge;       // slave frame start
  logic                fr_reg;        // master frame polarity
  logic                fr_now;        // polarity in use
  logic [LINE_W-1:0]   line;          // line and common counter
  logic [LINE_W-1:0]   lat_line;      // line now displayed
  logic [NSEG-1:0]     seg_on;        // latched segment bits
  logic [NCOM-1:0]     com_on;        // selected common
  logic [PAGE_W+COL_W-1:0] addr;      // host ram address
  //////////////////////////////////////////////////////////////
  // line a common output stands for
  function automatic logic [LINE_W-1:0] com_line(input int k, input logic m);
    // slave reversed, upper half of lines
    if (m)
      com_line = LINE_W'(k);
    else
      com_line = LINE_W'(NLINE - 1 - k);
  endfunction
  //////////////////////////////////////////////////////////////
  // host strobe decoder
  ldp_bus_port u_port (
    .clk     (CLK_IN),
    .rst_n   (RESETN_IN),
    .style68 (style68),
    .cs_n    (CHIP_SELECT_N_IN),
    .dcs     (DATA_COMMAND_SELECT_IN),
    .stb     (ENABLE_READ_IN),
    .dir     (DIR_WRITE_IN),
    .din     (DATA_IN),
    .oe      (DATA_OE_OUT),
    .bus     (bus.port)
  );
  //////////////////////////////////////////////////////////////
  // reset pin: level picks bus style, an edge resets
  // the pin is not gated by chip select
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      rst_q <= 1'b1;
    else
      rst_q <= RESET_BUS_STYLE_IN;
  end
  // edge, not level: a held pin resets only once
  assign srst    = rst_q != RESET_BUS_STYLE_IN;
  // high selects 68 style, low 80 style
  assign style68 = rst_q;
  // strap read as a plain level
  assign master  = MASTER_SEL_IN;
  //////////////////////////////////////////////////////////////
  // host address from page and column
  assign addr = {page, col};
  // column counter and page register
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      col  <= COL_RST;
      page <= PAGE_RST;
    end else if (srst) begin
      // pin edge wins over any access
      col  <= COL_RST;
      page <= PAGE_RST;
    end else if (bus.wr_stb && !bus.a0) begin
      // command byte
      if (!bus.wdata[DW-1])
        col <= bus.wdata[COL_W-1:0];
      else if (bus.wdata[DW-1 -: 2] == CMD_PAGE)
        page <= bus.wdata[PAGE_W-1:0];
    end else if ((bus.wr_stb || bus.rd_stb) && bus.a0) begin
      // data access: stop at the last column
      if (col != COL_LAST)
        col <= col + COL_W'(1);
    end
  end
  // ram write, data only; contents survive reset
  always_ff @(posedge CLK_IN) begin
    if (bus.wr_stb && bus.a0)
      mem[addr] <= bus.wdata;
  end
  // read latch: bus shows old latch, ram moves in
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      rd_latch <= '0;
    else if (bus.rd_stb && bus.a0)
      rd_latch <= mem[addr];
  end
  //////////////////////////////////////////////////////////////
  // status: never busy, style, strap, polarity
  always_comb begin
    status            = '0;
    status[ST_BUSY]   = 1'b0;
    status[ST_STYLE]  = style68;
    status[ST_MASTER] = master;
    status[ST_FRAME]  = fr_now;
  end
  // output byte register; select low reads status
  // one cycle lag after select moves, well inside any strobe
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      DATA_OUT <= '0;
    else if (DATA_COMMAND_SELECT_IN)
      DATA_OUT <= rd_latch;
    else
      DATA_OUT <= status;
  end
  //////////////////////////////////////////////////////////////
  // line clock and frame input edge detection
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lclk_q <= 1'b0;
      frin_q <= 1'b0;
    end else begin
      lclk_q <= LINE_CLOCK_IN;
      frin_q <= FRAME_POLARITY_IN;
    end
  end
  // both edges count
  assign lclk_edge = lclk_q != LINE_CLOCK_IN;
  // slave locks to master frame edges
  assign fr_edge   = !master && (frin_q != FRAME_POLARITY_IN);
  //////////////////////////////////////////////////////////////
  // line and common counter
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      line <= LINE_RST;
    else if (srst || fr_edge)
      line <= LINE_RST;
    else if (lclk_edge)
      line <= (line == LINE_LAST) ? LINE_RST : line + LINE_W'(1);
  end
  // master polarity flips at frame end
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN)
      fr_reg <= 1'b0;
    else if (srst)
      fr_reg <= 1'b0;
    else if (master && lclk_edge && line == LINE_LAST)
      fr_reg <= !fr_reg;
  end
  // polarity in use: own as master, pin as slave
  assign fr_now = (HAS_COM && master) ? fr_reg : FRAME_POLARITY_IN;
  // pin direction by strap; segment only parts listen
  assign FRAME_POLARITY_OUT    = fr_reg;
  assign FRAME_POLARITY_OE_OUT = HAS_COM && master;
  //////////////////////////////////////////////////////////////
  // display latch: one ram line per line clock edge
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      seg_on   <= '0;
      lat_line <= LINE_RST;
    end else if (lclk_edge) begin
      lat_line <= line;
      for (int j = 0; j < NSEG; j++)
        seg_on[j] <= mem[{line[LINE_W-1 -: PAGE_W], COL_W'(j)}][line[BIT_W-1:0]];
    end
  end
  // common decode, order reversed as slave
  always_comb begin
    for (int k = 0; k < NCOM; k++)
      com_on[k] = lat_line == com_line(k, master);
  end
  //////////////////////////////////////////////////////////////
  // drive code stages
  ldp_drive #(
    .IS_COM (1'b0),
    .N      (NSEG)
  ) u_seg (
    .clk    (CLK_IN),
    .rst_n  (RESETN_IN),
    .fr     (fr_now),
    .on     (seg_on),
    .sel    (SEGMENT_OUTPUT_SEL_OUT)
  );
  ldp_drive #(
    .IS_COM (1'b1),
    .N      (NCOM)
  ) u_com (
    .clk    (CLK_IN),
    .rst_n  (RESETN_IN),
    .fr     (fr_now),
    .on     (com_on),
    .sel    (COMMON_OUTPUT_SEL_OUT)
  );
  //////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_rd_drive: assert property (!style68 && !CHIP_SELECT_N_IN
    && !ENABLE_READ_IN |-> DATA_OE_OUT)
    else $error("80 read not driven");
  a_idle_float: assert property (CHIP_SELECT_N_IN |-> !DATA_OE_OUT)
    else $error("bus driven while deselected");
  a_fr_dir: assert property (FRAME_POLARITY_OE_OUT == master)
    else $error("frame pin direction wrong");
  a_reset_edge: assert property ($changed(RESET_BUS_STYLE_IN)
    |=> col == COL_RST && page == PAGE_RST && line == LINE_RST)
    else $error("pin edge did not reset");
  a_line_adv: assert property (lclk_edge && !srst && !fr_edge
    && line != LINE_LAST |=> line == $past(line) + LINE_W'(1))
    else $error("line counter did not advance");
  a_slave_rev: assert property (!master && lat_line == LINE_LAST
    |-> com_on[0] && !com_on[NCOM-1])
    else $error("slave common order wrong");
  a_status_read: assert property (!DATA_COMMAND_SELECT_IN
    |=> DATA_OUT[ST_STYLE] == $past(style68))
    else $error("status byte not returned");
  c_frame_flip: cover property (master && $changed(fr_reg));
  c_slave_frame: cover property (fr_edge);
  c_data_read: cover property (bus.rd_stb && bus.a0);
endmodule

/* File: tb_ldp_top.sv */
// self-checking bench for the lcd driver host port and panel drive codes
// assumes ldp_host as processor; design assertions live in the design
`timescale 1ns/10ps
module tb_ldp_top;
  import ldp_pkg::*;
  ////////////////////////////////////////////////
  logic              clk;          // 40 MHz
  logic              rst_n;        // async reset
  logic              sty;          // reset and bus style pin
  logic              line_clk;     // panel line clock
  logic              ms;           // master strap
  logic              fr_in;        // polarity from a master
  logic              cs_n;
  logic              dcs;
  logic              strb;
  logic              dirw;
  logic [DW-1:0]     hd;           // host side of the bus
  logic [DW-1:0]     dout;
  logic              doe;
  logic [DW-1:0]     bus;          // resolved data bus
  logic              fr_out;
  logic              fr_oe;
  logic [2*NSEG-1:0] seg;
  logic [2*NCOM-1:0] com;
  int                failures;
  int                n_checks;
  logic [31:0]       exp_q[$];     // expected results
  logic [31:0]       obs_q[$];     // observed results
  logic [DW-1:0]     ram_m[NWORD]; // expected display memory
  logic [DW-1:0]     lat_m;        // expected read latch
  logic [PAGE_W-1:0] pg;
  logic [COL_W-1:0]  col;
  logic              fr_m;         // polarity in use
  logic [31:0]       rnd;
  logic [DW-1:0]     rd;

  assign bus = doe ? dout : hd;  // device wins only while it drives
  always #12.5 clk = ~clk;

  ldp_top dut (.CLK_IN(clk), .RESETN_IN(rst_n), .RESET_BUS_STYLE_IN(sty),
    .CHIP_SELECT_N_IN(cs_n), .DATA_COMMAND_SELECT_IN(dcs), .ENABLE_READ_IN(strb),
    .DIR_WRITE_IN(dirw), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_OUT(doe),
    .LINE_CLOCK_IN(line_clk), .MASTER_SEL_IN(ms), .FRAME_POLARITY_IN(fr_in),
    .FRAME_POLARITY_OUT(fr_out), .FRAME_POLARITY_OE_OUT(fr_oe),
    .SEGMENT_OUTPUT_SEL_OUT(seg), .COMMON_OUTPUT_SEL_OUT(com));
  ldp_host host (.clk(clk), .style68(sty), .bus(bus), .cs_n(cs_n), .dcs(dcs),
    .strb(strb), .dirw(dirw), .d(hd));

  ////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected drive codes of one displayed line; c picks commons
  function automatic logic [31:0] panel(input int ln, input logic f, input logic c);
    logic [31:0] v;
    logic        b;
    for (int k = 0; k < 16; k++) begin
      if (c) begin
        b = ms ? (k == ln) : (31 - k == ln);
        v[2*k+:2] = f ? (b ? COM_V5 : COM_V1) : (b ? COM_VDD : COM_V4);
      end else begin
        b = ram_m[ln[4:3] * 16 + k][ln[2:0]];
        v[2*k+:2] = f ? (b ? SEG_VDD : SEG_V2) : (b ? SEG_V5 : SEG_V3);
      end
    end
    return v;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic note(input logic [31:0] want, input logic [31:0] seen);
    exp_q.push_back(want);
    obs_q.push_back(seen);
  endtask

  // comparator: oldest expectation against each result as it lands
  always @(posedge clk) begin
    while (obs_q.size() > 0) begin
      check(obs_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // host write; the model follows data, column and page commands
  task automatic wr(input logic a0, input logic [DW-1:0] v);
    host.access(1'b1, a0, 1'b1, v, rd);
    if (a0) begin
      ram_m[{pg, col}] = v;
      if (col != COL_LAST) col++;               // column sticks at its end
    end else if (!v[7]) begin
      col = v[COL_W-1:0];
    end else if (v[7:6] == CMD_PAGE) begin
      pg = v[PAGE_W-1:0];
    end
  endtask

  // host read of data (latched, one access late) or status
  task automatic rdb(input logic a0, input logic chk);
    logic [DW-1:0] want;
    want = a0 ? lat_m : {1'b0, sty, ms, fr_m, 4'h0};
    host.access(1'b0, a0, 1'b1, 8'h00, rd);
    if (a0) begin
      lat_m = ram_m[{pg, col}];
      if (col != COL_LAST) col++;
    end
    if (chk) note({24'h0, want}, {24'h0, rd});
  endtask

  // one line clock edge, then codes compared once settled
  task automatic step(input int ln, input logic f, input logic chk);
    @(posedge clk);
    #2 line_clk = ~line_clk;
    repeat (4) @(posedge clk);
    #1;
    if (chk) begin
      note(panel(ln, f, 1'b0), seg);
      note(panel(ln, f, 1'b1), com);
    end
  endtask

  // set page and column 0, then the discarded read
  task automatic seek(input int p);
    wr(1'b0, {CMD_PAGE, 6'(p)});
    wr(1'b0, 8'h00);
    rdb(1'b1, 1'b0);
  endtask

  ////////////////////////////////////////////////
  initial begin
    logic [DW-1:0] v;
    clk = 1'b0; rst_n = 1'b0; sty = 1'b1; line_clk = 1'b0;
    ms = 1'b1; fr_in = 1'b0; rnd = 32'h85e7c930;
    failures = 0; n_checks = 0; pg = PAGE_RST; col = COL_RST; fr_m = 1'b0;
    repeat (6) @(posedge clk);
    #1 note({NSEG{SEG_V3}}, seg);
    note({NCOM{COM_V4}}, com);
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    // 68 style: status, fill every page, one write past the last column
    rdb(1'b0, 1'b1);
    for (int p = 0; p < 4; p++) begin
      wr(1'b0, {CMD_PAGE, 6'(p)});
      wr(1'b0, 8'h00);
      for (int i = 0; i < 17; i++) begin
        rnd = lfsr(rnd);
        wr(1'b1, rnd[7:0]);
      end
      seek(p);
      for (int i = 0; i < 17; i++) rdb(1'b1, 1'b1);
    end
    $display("test 68 style fill and read back done");
    // deselected: write and read both ignored, bus left undriven
    wr(1'b0, 8'h00);
    v = hd;
    host.access(1'b1, 1'b1, 1'b0, ~ram_m[{pg, col}], rd);
    v = hd;
    host.access(1'b0, 1'b1, 1'b0, 8'h00, rd);
    note({24'h0, v}, {24'h0, rd});
    note(32'h0, {31'h0, doe});
    seek(pg);
    rdb(1'b1, 1'b1);
    $display("test chip select refusal done");
    // pin edge resets pointers and selects 80 style
    @(posedge clk);
    #2 sty = 1'b0;
    host.idle(1'b0);
    pg = PAGE_RST; col = COL_RST; fr_m = 1'b0;
    repeat (4) @(posedge clk);
    rdb(1'b0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      wr(1'b1, rnd[7:0]);
    end
    seek(PAGE_RST);
    for (int i = 0; i < 16; i++) rdb(1'b1, 1'b1);
    $display("test 80 style after pin reset done");
    // master scan: a frame at one polarity, then the first eight lines of the next frame
    // the last line of a frame is shown after the master polarity flips
    for (int i = 0; i < 32; i++) step(i, i == 31, 1'b1);
    fr_m = 1'b1;
    rdb(1'b0, 1'b1);
    note(32'h3, {30'h0, fr_oe, fr_out});
    for (int i = 0; i < 8; i++) step(i, 1'b1, 1'b1);
    $display("test master scan done");
    // slave: polarity from the pin, commons in reverse
    @(posedge clk);
    #2 ms = 1'b0;
    repeat (2) @(posedge clk);
    #2 fr_in = 1'b1;
    repeat (4) @(posedge clk);
    note(32'h0, {31'h0, fr_oe});
    // a full frame so the reversed upper commons all light
    for (int i = 0; i < 32; i++) step(i, 1'b1, 1'b1);
    rdb(1'b0, 1'b1);
    $display("test slave scan done");
    repeat (3) @(posedge clk);
    print_verdict();
  end

  // watchdog: whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule
